// >>> inc/rfg_consts.vh
// Purpose: Constants for the receive frame capture guard.
// Assumes: Included by bare name from design files.
// Notes: Register offsets, field positions and reset values.
`ifndef RFG_CONSTS_VH
`define RFG_CONSTS_VH
`define RFG_ADDR_DELIM 6'h0B
`define RFG_ADDR_CTRL2 6'h0C
`define RFG_DELIM_RST 8'hA7
`define RFG_CTRL2_RST 8'h20
`define RFG_GUARD_BIT 7
`define RFG_TRX_LISTEN 5'h06
`define RFG_TRX_LISTEN_AA 5'h16
`define RFG_FB_SEL_IDLE 1'b1
`endif

// >>> src/rfg_sync3.v
// Purpose: Three-stage synchroniser with agreement qualifier for one pin.
// Assumes: Single clock domain CLK_SYS, async active-low reset.
// Notes: A change counts once stages two and three agree.
`timescale 1ns/100ps
module rfg_sync3 #(
  parameter [0:0] INIT = 1'b0
) (
  input wire clk,
  input wire arst_n,
  input wire din,
  output reg dout
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  // Shift chain; first stage feeds only the second
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      dout <= INIT;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout <= s3_q;
      end
    end
  end
endmodule

// >>> src/rfg_guard.v
// Purpose: Receive frame buffer guard and start delimiter control.
// Assumes: Host register writes arrive decoded as address/data strobes from the SPI front end.
// Notes: Frame buffer read end is seen as the rising edge of the chip select pin.
`timescale 1ns/100ps
`include "rfg_consts.vh"
// Behaviour
// RULE1: Keep receiving; unguarded frames overwrite buffer
// RULE2: Guarded buffer blocks radio until select rises
// RULE3: Basic mode guards frames with valid checksum
// RULE4: Extended mode guards frames raising frame end
// RULE5: Guard only if enabled and listening
// RULE6: Host buffer writes pass while guarded
// RULE7: Release on read-end select rise or leaving listen
// RULE8: Guard enable resets zero; one enables
// RULE9: Delimiter is one octet, ends sync header
// RULE10: Delimiter aligns bytes, never stored
// RULE11: Transmit delimiter LSB first after preamble
// RULE12: Delimiter register resets to A7, writable
// RULE13: Frame start only on match plus header
// RULE14: Mismatching delimiter means no synchronisation
// RULE15: Host should avoid zero low nibble
// RULE16: After release next good frame overwrites
module rfg_guard (
  input wire CLK_SYS,
  input wire ARST_N,
  input wire REG_WE,
  input wire [5:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  output reg [7:0] REG_RDATA,
  input wire SEL_N_PIN,
  input wire FB_READ_ACTIVE,
  input wire HOST_FB_WE,
  input wire [4:0] TRX_STATE,
  input wire EXT_MODE,
  input wire RX_BYTE_VALID,
  input wire [7:0] RX_BYTE,
  input wire RX_FRAME_END,
  input wire RX_FCS_OK,
  input wire RX_PHR_VALID,
  input wire RX_ABORT,
  output wire RX_BUF_WE,
  output reg [7:0] RX_BUF_WDATA,
  output wire HOST_BUF_WE,
  output reg RX_SYNCED,
  output reg FRAME_START,
  output reg FRAME_END_EVENT,
  output reg GUARD_ACTIVE,
  input wire TX_DELIM_LOAD,
  input wire TX_BIT_STROBE,
  output reg TX_DELIM_BIT,
  output reg TX_DELIM_BUSY
);
  reg [7:0] delimiter_match_value_q;
  reg [7:0] transceiver_control_two_q;
  reg [7:0] shift_q;
  reg [2:0] tx_cnt_q;
  reg [7:0] tx_sh_q;
  reg read_seen_q;
  reg sel_prev_q;
  wire sel_sync;
  wire listening;
  wire guard_en;
  wire sel_rise;
  wire delim_hit;
  wire frame_lock;
  // Receive state machine, one-hot
  localparam [2:0] ST_HUNT = 3'b001;
  localparam [2:0] ST_HDR = 3'b010;
  localparam [2:0] ST_DATA = 3'b100;
  reg [2:0] st_q;
  reg [2:0] st_d;

  ////////////////////////////////////////////////////////////////////////////////
  // Chip select synchroniser
  rfg_sync3 #(.INIT(`RFG_FB_SEL_IDLE)) u_sel_sync (
    .clk(CLK_SYS),
    .arst_n(ARST_N),
    .din(SEL_N_PIN),
    .dout(sel_sync)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Register file
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      delimiter_match_value_q <= `RFG_DELIM_RST; // [RULE12]
      transceiver_control_two_q <= `RFG_CTRL2_RST; // [RULE8]
    end else if (REG_WE) begin
      if (REG_ADDR == `RFG_ADDR_DELIM) begin
        delimiter_match_value_q <= REG_WDATA; // [RULE12]
      end
      if (REG_ADDR == `RFG_ADDR_CTRL2) begin
        transceiver_control_two_q <= REG_WDATA; // [RULE8]
      end
    end
  end

  // Readback; unmapped offsets read zero
  always @* begin
    case (REG_ADDR)
      `RFG_ADDR_DELIM: REG_RDATA = delimiter_match_value_q;
      `RFG_ADDR_CTRL2: REG_RDATA = transceiver_control_two_q;
      default: REG_RDATA = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Guard qualification
  assign listening = (TRX_STATE == `RFG_TRX_LISTEN) || (TRX_STATE == `RFG_TRX_LISTEN_AA);
  assign guard_en = transceiver_control_two_q[`RFG_GUARD_BIT] && listening; // [RULE5]
  assign sel_rise = sel_sync && !sel_prev_q;
  // Frame completing now earns protection per mode
  assign frame_lock = RX_FRAME_END && st_q == ST_DATA && (EXT_MODE || RX_FCS_OK); // [RULE3] [RULE4]

  // Track a buffer read within the current select window and the guard flag
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      sel_prev_q <= 1'b1;
      read_seen_q <= 1'b0;
      GUARD_ACTIVE <= 1'b0;
    end else begin
      sel_prev_q <= sel_sync;
      if (sel_rise) begin
        read_seen_q <= 1'b0;
      end else if (FB_READ_ACTIVE && !sel_sync) begin
        read_seen_q <= 1'b1;
      end
      if (!guard_en) begin
        GUARD_ACTIVE <= 1'b0; // [RULE7]
      end else if (frame_lock) begin
        GUARD_ACTIVE <= 1'b1; // [RULE2]
      end else if (sel_rise && read_seen_q) begin
        GUARD_ACTIVE <= 1'b0; // [RULE7] [RULE16]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Buffer write gating
  assign RX_BUF_WE = RX_BYTE_VALID && st_q == ST_DATA && !GUARD_ACTIVE; // [RULE1] [RULE2]
  assign HOST_BUF_WE = HOST_FB_WE; // [RULE6]

  ////////////////////////////////////////////////////////////////////////////////
  // Delimiter hunt and receive sequencing
  assign delim_hit = RX_BYTE_VALID && (RX_BYTE == delimiter_match_value_q); // [RULE14]

  always @* begin
    st_d = st_q;
    case (st_q)
      ST_HUNT: begin
        if (delim_hit) begin
          st_d = ST_HDR; // [RULE9]
        end
      end
      ST_HDR: begin
        if (RX_ABORT) begin
          st_d = ST_HUNT;
        end else if (RX_PHR_VALID) begin
          st_d = ST_DATA;
        end
      end
      ST_DATA: begin
        if (RX_FRAME_END || RX_ABORT) begin
          st_d = ST_HUNT; // [RULE1]
        end
      end
      default: st_d = ST_HUNT;
    endcase
  end

  // Receive outputs; delimiter byte never forwarded
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      st_q <= ST_HUNT;
      shift_q <= 8'h00;
      RX_BUF_WDATA <= 8'h00;
      RX_SYNCED <= 1'b0;
      FRAME_START <= 1'b0;
      FRAME_END_EVENT <= 1'b0;
    end else begin
      st_q <= st_d;
      if (RX_BYTE_VALID) begin
        shift_q <= RX_BYTE;
      end
      if (RX_BYTE_VALID && st_q == ST_DATA) begin
        RX_BUF_WDATA <= RX_BYTE; // [RULE10]
      end
      RX_SYNCED <= (st_d != ST_HUNT); // [RULE14]
      FRAME_START <= (st_q == ST_HDR) && RX_PHR_VALID && !RX_ABORT; // [RULE13]
      FRAME_END_EVENT <= (st_q == ST_DATA) && RX_FRAME_END;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit delimiter serialiser, LSB first once preamble is done
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      tx_sh_q <= 8'h00;
      tx_cnt_q <= 3'h0;
      TX_DELIM_BIT <= 1'b0;
      TX_DELIM_BUSY <= 1'b0;
    end else if (TX_DELIM_LOAD) begin
      tx_sh_q <= delimiter_match_value_q;
      tx_cnt_q <= 3'h0;
      TX_DELIM_BUSY <= 1'b1;
    end else if (TX_DELIM_BUSY && TX_BIT_STROBE) begin
      TX_DELIM_BIT <= tx_sh_q[0]; // [RULE11]
      tx_sh_q <= {1'b0, tx_sh_q[7:1]};
      tx_cnt_q <= tx_cnt_q + 3'h1;
      if (tx_cnt_q == 3'h7) begin
        TX_DELIM_BUSY <= 1'b0;
      end
    end
  end
endmodule

// >>> tb/rfg_guard_properties.sv
// Purpose: Port timing checks for the capture guard.
// Assumes: Bound to rfg_guard, one clock.
// Notes: Sees design ports only.
`timescale 1ns/100ps
module rfg_guard_props (
  input logic CLK_SYS,
  input logic ARST_N,
  input logic REG_WE,
  input logic HOST_FB_WE,
  input logic HOST_BUF_WE,
  input logic RX_BUF_WE,
  input logic GUARD_ACTIVE,
  input logic RX_SYNCED,
  input logic RX_FRAME_END,
  input logic RX_FCS_OK,
  input logic EXT_MODE,
  input logic FRAME_END_EVENT,
  input logic RX_PHR_VALID,
  input logic FRAME_START,
  input logic TX_DELIM_LOAD,
  input logic TX_DELIM_BUSY,
  input logic [5:0] REG_ADDR,
  input logic [7:0] REG_WDATA,
  input logic [7:0] REG_RDATA,
  input logic [4:0] TRX_STATE
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  // Delimiter write, then the same place read back
  sequence s_delim_wr;
    REG_WE && REG_ADDR == 6'h0B ##1 !REG_WE && REG_ADDR == 6'h0B;
  endsequence
  a_delim_readback: assert property (s_delim_wr |-> REG_RDATA == $past(REG_WDATA))
    else $error("delimiter readback differs");
  a_host_write_pass: assert property (HOST_BUF_WE == HOST_FB_WE)
    else $error("host buffer write gated");
  a_guard_blocks_rx: assert property (GUARD_ACTIVE |-> !RX_BUF_WE)
    else $error("radio write while guarded");
  a_end_event_next: assert property (RX_FRAME_END && RX_SYNCED |=> FRAME_END_EVENT)
    else $error("frame end event missing");
  a_guard_cause: assert property ($rose(GUARD_ACTIVE) |->
    $past(RX_FRAME_END && (EXT_MODE || RX_FCS_OK) && (TRX_STATE == 5'h06 || TRX_STATE == 5'h16)))
    else $error("guard set without cause");
  a_leave_listen_drop: assert property (GUARD_ACTIVE && TRX_STATE != 5'h06 && TRX_STATE != 5'h16 |=>
    !GUARD_ACTIVE) else $error("guard kept outside listen");
  a_start_after_header: assert property (FRAME_START |-> $past(RX_PHR_VALID))
    else $error("frame start without header");
  a_tx_busy_load: assert property (TX_DELIM_LOAD |=> TX_DELIM_BUSY)
    else $error("send not busy after load");
endmodule
bind rfg_guard rfg_guard_props i_props (
  .CLK_SYS(CLK_SYS),
  .ARST_N(ARST_N),
  .REG_WE(REG_WE),
  .HOST_FB_WE(HOST_FB_WE),
  .HOST_BUF_WE(HOST_BUF_WE),
  .RX_BUF_WE(RX_BUF_WE),
  .GUARD_ACTIVE(GUARD_ACTIVE),
  .RX_SYNCED(RX_SYNCED),
  .RX_FRAME_END(RX_FRAME_END),
  .RX_FCS_OK(RX_FCS_OK),
  .EXT_MODE(EXT_MODE),
  .FRAME_END_EVENT(FRAME_END_EVENT),
  .RX_PHR_VALID(RX_PHR_VALID),
  .FRAME_START(FRAME_START),
  .TX_DELIM_LOAD(TX_DELIM_LOAD),
  .TX_DELIM_BUSY(TX_DELIM_BUSY),
  .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA),
  .REG_RDATA(REG_RDATA),
  .TRX_STATE(TRX_STATE)
);

// >>> tb/rfg_host_model.sv
// Purpose: Host side of a frame buffer read.
// Assumes: Drives select and read-command flag.
// Notes: Hold length sets prompt or slow host.
`timescale 1ns/100ps
module rfg_host_model (
  input logic clk,
  output logic sel_n,
  output logic fb_rd
);
  initial begin
    sel_n = 1'b1;
    fb_rd = 1'b0;
  end
  // Select low with read command, then select released
  task automatic fb_read(input int n);
    @(negedge clk);
    sel_n = 1'b0;
    fb_rd = 1'b1;
    repeat (n) @(negedge clk);
    fb_rd = 1'b0;
    sel_n = 1'b1;
  endtask
endmodule

// >>> tb/rfg_guard_bench.sv
// Purpose: Directed test of the capture guard.
// Assumes: Inputs change at falling edge.
// Notes: Abort pulsed once, after a delimiter.
`timescale 1ns/100ps
module rfg_guard_bench;
  logic CLK_SYS = '0, ARST_N = '0, REG_WE = '0, HOST_FB_WE = '0, EXT_MODE = '0, RX_BYTE_VALID = '0;
  logic RX_FRAME_END = '0, RX_FCS_OK = '0, RX_PHR_VALID = '0, RX_ABORT = '0, TX_DELIM_LOAD = '0;
  logic TX_BIT_STROBE = '0, SEL_N_PIN, FB_READ_ACTIVE, RX_BUF_WE, HOST_BUF_WE, RX_SYNCED, FRAME_START;
  logic FRAME_END_EVENT, GUARD_ACTIVE, TX_DELIM_BIT, TX_DELIM_BUSY;
  logic [5:0] REG_ADDR = '0;
  logic [7:0] REG_WDATA = '0, RX_BYTE = '0, REG_RDATA, RX_BUF_WDATA, tx_v;
  logic [4:0] TRX_STATE = 5'h06;
  int n_mismatch = 0, num_checks = 0, n_we = 0, n_fs = 0, n_sy = 0, n_fe = 0;
  rfg_guard i_dut (.*);
  rfg_host_model i_host (.clk(CLK_SYS), .sel_n(SEL_N_PIN), .fb_rd(FB_READ_ACTIVE));
  initial forever #10 CLK_SYS = ~CLK_SYS;
  // Count radio writes, frame starts, synced cycles and frame end events
  always @(posedge CLK_SYS) begin
    n_we += (RX_BUF_WE === 1'b1);
    n_fs += (FRAME_START === 1'b1);
    n_sy += (RX_SYNCED === 1'b1);
    n_fe += (FRAME_END_EVENT === 1'b1);
  end
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [5:0] a, logic [7:0] d);
    @(negedge CLK_SYS) {REG_ADDR, REG_WDATA, REG_WE} = {a, d, 1'b1};
    @(negedge CLK_SYS) REG_WE = 1'b0;
  endtask
  task automatic rd(logic [5:0] a, logic [7:0] e);
    @(negedge CLK_SYS) REG_ADDR = a;
    #1 chk("register", e, REG_RDATA);
  endtask
  task automatic rx(logic [7:0] b);
    @(negedge CLK_SYS) {RX_BYTE, RX_BYTE_VALID} = {b, 1'b1};
    @(negedge CLK_SYS) RX_BYTE_VALID = 1'b0;
  endtask
  // Delimiter, header, two data bytes, end with checksum flag
  task automatic frame(logic [7:0] d, logic fcs);
    n_we = 0;
    n_fs = 0;
    n_sy = 0;
    n_fe = 0;
    rx(d);
    @(negedge CLK_SYS) RX_PHR_VALID = 1'b1;
    @(negedge CLK_SYS) RX_PHR_VALID = 1'b0;
    rx(8'h3C);
    rx(8'hC3);
    @(negedge CLK_SYS) {RX_FRAME_END, RX_FCS_OK} = {1'b1, fcs};
    @(negedge CLK_SYS) RX_FRAME_END = 1'b0;
    @(negedge CLK_SYS);
  endtask
  // Host read, then bounded wait for the guard to drop
  task automatic release_wait(int n);
    int k;
    i_host.fb_read(n);
    for (k = 0; k < 20 && GUARD_ACTIVE !== 1'b0; k++) @(negedge CLK_SYS);
    chk("guard", 0, GUARD_ACTIVE);
    // Wait bound used up: the mismatch is counted, end the run
    if (k == 20) stop_test;
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge CLK_SYS);
    ARST_N = 1'b1;
    rd(6'h0B, 8'hA7);
    rd(6'h0C, 8'h20);
    rd(6'h3F, 8'h00);
    frame(8'hA7, 1'b1);
    chk("starts", 1, n_fs);
    chk("writes", 2, n_we);
    chk("buffer data", 8'hC3, RX_BUF_WDATA);
    chk("guard", 0, GUARD_ACTIVE);
    wr(6'h0C, 8'h80);
    rd(6'h0C, 8'h80);
    frame(8'hA7, 1'b0);
    chk("guard", 0, GUARD_ACTIVE);
    frame(8'hA7, 1'b1);
    chk("guard", 1, GUARD_ACTIVE);
    frame(8'hA7, 1'b1);
    chk("writes", 0, n_we);
    // Host write held across an edge while the guard stands
    HOST_FB_WE = 1'b1;
    #1 chk("host write", 1, HOST_BUF_WE);
    @(negedge CLK_SYS) HOST_FB_WE = 1'b0;
    release_wait(8);
    frame(8'hA7, 1'b1);
    chk("writes", 2, n_we);
    release_wait(14);
    {EXT_MODE, TRX_STATE} = {1'b1, 5'h16};
    frame(8'hA7, 1'b0);
    chk("guard", 1, GUARD_ACTIVE);
    chk("end events", 1, n_fe);
    TRX_STATE = 5'h08;
    @(negedge CLK_SYS) chk("guard", 0, GUARD_ACTIVE);
    frame(8'hA7, 1'b1);
    chk("guard", 0, GUARD_ACTIVE);
    {EXT_MODE, TRX_STATE} = {1'b0, 5'h06};
    wr(6'h0B, 8'h5B);
    frame(8'hA7, 1'b0);
    chk("starts", 0, n_fs);
    chk("writes", 0, n_we);
    chk("synced", 0, n_sy);
    chk("end events", 0, n_fe);
    frame(8'h5B, 1'b0);
    chk("starts", 1, n_fs);
    chk("synced", 8, n_sy);
    chk("end events", 1, n_fe);
    // Delimiter seen, then the frame is dropped before its header
    rx(8'h5B);
    chk("synced", 1, RX_SYNCED);
    @(negedge CLK_SYS) RX_ABORT = 1'b1;
    @(negedge CLK_SYS) RX_ABORT = 1'b0;
    chk("synced", 0, RX_SYNCED);
    TX_DELIM_LOAD = 1'b1;
    @(negedge CLK_SYS) TX_DELIM_LOAD = 1'b0;
    for (int b = 0; b < 8; b++) begin
      TX_BIT_STROBE = 1'b1;
      @(negedge CLK_SYS) {TX_BIT_STROBE, tx_v[b]} = {1'b0, TX_DELIM_BIT};
      @(negedge CLK_SYS);
    end
    chk("send bits", 8'h5B, tx_v);
    chk("send busy", 0, TX_DELIM_BUSY);
    stop_test;
  end
  initial begin
    #100us n_mismatch++;
    stop_test;
  end
endmodule
